//--- rmcfg_regs.svh
`ifndef RMCFG_REGS_SVH
`define RMCFG_REGS_SVH

// ========
// Register offsets on the configuration port.
`define RMCFG_OFF_BIT_RATE_D 5'h04
`define RMCFG_OFF_AMP_RAMP   5'h05
`define RMCFG_OFF_FREQ1_R    5'h06
`define RMCFG_OFF_FREQ1_P    5'h07
`define RMCFG_OFF_FREQ1_S    5'h08
`define RMCFG_OFF_FREQ2_R    5'h09
`define RMCFG_OFF_FREQ2_P    5'h0A
`define RMCFG_OFF_FREQ2_S    5'h0B
`define RMCFG_OFF_BUFFER     5'h0C
`define RMCFG_NUM_REGS       9

// ========
// Reset values.
`define RMCFG_RST_BIT_RATE_D 8'h1F
`define RMCFG_RST_AMP_RAMP   8'hC6
`define RMCFG_RST_FREQ1_R    8'h6B
`define RMCFG_RST_FREQ1_P    8'h2A
`define RMCFG_RST_FREQ1_S    8'h1E
`define RMCFG_RST_FREQ2_R    8'h77
`define RMCFG_RST_FREQ2_P    8'h2F
`define RMCFG_RST_FREQ2_S    8'h19
`define RMCFG_RST_BUFFER     8'h0F

// ========
// Field positions.
`define RMCFG_RAMP_HI        7
`define RMCFG_RAMP_LO        6
`define RMCFG_LOW_POWER_BIT  5
`define RMCFG_TRIM_HI        2
`define RMCFG_TRIM_LO        1
`define RMCFG_SET_SELECT_BIT 0
`define RMCFG_DEPTH_HI       7
`define RMCFG_DEPTH_LO       6
`define RMCFG_THRESH_HI      5
`define RMCFG_THRESH_LO      0
`define RMCFG_READ_FLAG_BIT  7
`define RMCFG_DEPTH_STEP     7'h10

// ========
// Timing: clock period and amplifier ramp times in nanoseconds.
`define RMCFG_CLK_PERIOD_NS  10
`define RMCFG_RAMP_0_NS      3000
`define RMCFG_RAMP_1_NS      8500
`define RMCFG_RAMP_2_NS      15000
`define RMCFG_RAMP_3_NS      23000
`define RMCFG_NS_TO_CYC(t)   (((t) + `RMCFG_CLK_PERIOD_NS - 1) / `RMCFG_CLK_PERIOD_NS)

`endif

//--- rmcfg_pkg.sv
`default_nettype none

package rmcfg_pkg;

    // ========
    // Serial frame states, Gray coded along idle, address, data.
    typedef enum logic [1:0] {
        RMCFG_IDLE = 2'h0,
        RMCFG_ADDR = 2'h1,
        RMCFG_DATA = 2'h3
    } rmcfg_spi_state_type;

    // ========
    // Settings that steer the radio, decoded from the bank.
    typedef struct packed {
        logic [7:0] bit_rate_d;
        logic [1:0] amplifier_ramp_time;
        logic       rx_low_power;
        logic [1:0] vco_trim;
        logic       channel_set_select;
        logic [7:0] active_r_count;
        logic [7:0] active_p_count;
        logic [7:0] active_s_count;
        logic [6:0] fifo_depth_bytes;
        logic [5:0] fifo_threshold;
    } rmcfg_config_type;

endpackage

`default_nettype wire

//--- rmcfg_fifo_mem.sv
`timescale 1ns/1ns
`default_nettype none

module rmcfg_fifo_mem
    import rmcfg_pkg::*;
#(
    parameter int WIDTH  = 8,
    parameter int DEPTH  = 64,
    parameter int ADDR_W = 6
) (
    input  wire logic              i_clock,    // System clock.
    input  wire logic              i_sys_rst,  // Asynchronous reset, high.
    input  wire logic              i_wr_en,    // Write strobe.
    input  wire logic [ADDR_W-1:0] i_wr_addr,  // Write address.
    input  wire logic [WIDTH-1:0]  i_wr_data,  // Write data.
    input  wire logic [ADDR_W-1:0] i_rd_addr,  // Read address.
    output logic      [WIDTH-1:0]  o_rd_data   // Registered read data.
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ========
    // Storage array; left without reset so it maps onto block memory.
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // Read data is registered, so it trails the address by one cycle.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule

`default_nettype wire

//--- rmcfg_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rmcfg_regs.svh"

// Behaviour
// (R1) A bit lasts 2*(C+1)*(D+1) clocks and the host keeps the 8-bit D within 15 to 255.
// (R2) Ramp bits 7:6 pick a rise/fall time of 3, 8.5, 15 or 23 us.
// (R3) Ramp bit 5 at 1 turns receiver low-power mode on and at 0 off.
// (R4) Ramp bit 0 picks the first counter set at 0 and the second at 1.
// (R5) The first set is the R, P and S counters at 0x06, 0x07 and 0x08.
// (R6) The second set is the R, P and S counters at 0x09, 0x0A and 0x0B.
// (R7) Reset loads 0x6B, 0x2A, 0x1E into the first set and its own defaults into the second.
// (R8) Buffer bits 7:6 set the usable size to 16, 32, 48 or 64 bytes.
// (R9) Threshold B flags once B+1 bytes are held, with 15 after reset.
// (R10) In transmit the threshold drives line zero and its rise starts transmission.
// (R11) Buffer bytes carry no address and each select toggle that ends a whole byte steps the pointer.
// (R12) Ramp bits 4:3 read back what was written and steer nothing.
module rmcfg_top
    import rmcfg_pkg::*;
#(
    parameter int FIFO_DEPTH = 64,
    parameter int FIFO_AW    = 6
) (
    input  wire logic             i_clock,               // 100 MHz reference clock.
    input  wire logic             i_sys_rst,             // Asynchronous reset, high.
    input  wire logic             i_sck,                 // Serial clock from host.
    input  wire logic             i_sdi,                 // Serial data from host.
    input  wire logic             i_config_select_n,     // Register port select, low.
    input  wire logic             i_data_port_select_n,  // Buffer port select, low.
    output logic                  o_sdo,                 // Serial data to host.
    output logic                  o_sdo_oe_n,            // Low while o_sdo is driven.
    input  wire logic             i_receive_mode,        // High in receive, low in transmit.
    input  wire logic [7:0]       i_bit_rate_c,          // First bit-rate divider C.
    input  wire logic             i_rx_valid,            // Received byte strobe.
    input  wire logic [7:0]       i_rx_byte,             // Received byte.
    input  wire logic             i_tx_take,             // Modulator takes a byte.
    output logic      [7:0]       o_tx_byte,             // Byte at the buffer head.
    output logic                  o_fifo_empty,          // Buffer holds no byte.
    output logic                  o_fifo_full,           // Buffer at selected size.
    output logic                  o_fifo_threshold,      // Threshold reached.
    output logic                  o_interrupt_line_zero, // Threshold event in transmit.
    output logic                  o_tx_start,            // One-cycle start of transmit.
    output logic                  o_bit_tick,            // One pulse per bit period.
    output logic      [11:0]      o_ramp_cycles,         // Ramp time in clock cycles.
    output rmcfg_config_type      o_config               // Decoded settings.
);

    localparam int NREG = `RMCFG_NUM_REGS;
    localparam logic [NREG-1:0][7:0] BANK_RESET = {
        `RMCFG_RST_BUFFER,  `RMCFG_RST_FREQ2_S, `RMCFG_RST_FREQ2_P,
        `RMCFG_RST_FREQ2_R, `RMCFG_RST_FREQ1_S, `RMCFG_RST_FREQ1_P,
        `RMCFG_RST_FREQ1_R, `RMCFG_RST_AMP_RAMP, `RMCFG_RST_BIT_RATE_D};

    // ========
    // Helpers.
    function automatic logic rmcfg_in_map(input logic [4:0] a);
        return (a >= `RMCFG_OFF_BIT_RATE_D) && (a <= `RMCFG_OFF_BUFFER);
    endfunction

    function automatic logic [3:0] rmcfg_index(input logic [4:0] a);
        logic [4:0] d;
        d = a - `RMCFG_OFF_BIT_RATE_D;
        return d[3:0];
    endfunction

    function automatic logic [FIFO_AW-1:0] rmcfg_step(input logic [FIFO_AW-1:0] p,
                                                     input logic [6:0] size);
        logic [6:0] n;
        n = {{(7-FIFO_AW){1'b0}}, p} + 7'h01;
        return (n >= size) ? '0 : n[FIFO_AW-1:0];
    endfunction

    function automatic logic [11:0] rmcfg_ramp(input logic [1:0] sel);
        logic [11:0] c;
        c = 12'h000;
        unique case (sel)
            2'h0: c = 12'(`RMCFG_NS_TO_CYC(`RMCFG_RAMP_0_NS));
            2'h1: c = 12'(`RMCFG_NS_TO_CYC(`RMCFG_RAMP_1_NS));
            2'h2: c = 12'(`RMCFG_NS_TO_CYC(`RMCFG_RAMP_2_NS));
            2'h3: c = 12'(`RMCFG_NS_TO_CYC(`RMCFG_RAMP_3_NS));
        endcase
        return c;
    endfunction

    // ========
    // State.
    logic [NREG-1:0][7:0] bank, next_bank;
    rmcfg_spi_state_type  state, next_state;
    logic [2:0]           bit_cnt, next_bit_cnt;
    logic [7:0]           rx_shift, next_rx_shift;
    logic [7:0]           sdo_shift, next_sdo_shift;
    logic [4:0]           addr, next_addr;
    logic                 read_op, next_read_op;
    logic                 prev_sck, prev_data_n;
    logic [3:0]           fbit_cnt, next_fbit_cnt;
    logic [7:0]           fin_shift, next_fin_shift;
    logic [7:0]           fout_shift, next_fout_shift;
    logic [FIFO_AW-1:0]   wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [6:0]           count, next_count;
    logic                 interrupt_line_zero, next_interrupt_line_zero, tx_start, next_tx_start;
    logic                 sdo, next_sdo;
    logic [17:0]          div_cnt, next_div_cnt;
    logic                 tick, next_tick;

    logic       sck_rise, sck_fall, data_fall, data_rise, data_active;
    logic       push, pop, host_push, host_pop;
    logic [7:0] push_data, shifted;
    logic [6:0] depth_bytes, thresh_bytes;
    logic [7:0] ramp_reg, buf_reg;

    assign sck_rise    = i_sck & ~prev_sck;
    assign sck_fall    = ~i_sck & prev_sck;
    assign data_fall   = prev_data_n & ~i_data_port_select_n;
    assign data_rise   = ~prev_data_n & i_data_port_select_n;
    assign data_active = ~i_data_port_select_n & i_config_select_n;
    assign shifted     = {rx_shift[6:0], i_sdi};
    assign ramp_reg    = bank[rmcfg_index(`RMCFG_OFF_AMP_RAMP)];
    assign buf_reg     = bank[rmcfg_index(`RMCFG_OFF_BUFFER)];

    // ========
    // Register port: address byte (bit 7 read flag) then one data byte.
    always_comb begin
        next_bank      = bank;
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_rx_shift  = rx_shift;
        next_sdo_shift = sdo_shift;
        next_addr      = addr;
        next_read_op   = read_op;
        if (i_config_select_n) begin
            next_state   = RMCFG_IDLE;
            next_bit_cnt = 3'h0;
        end else begin
            unique case (state)
                RMCFG_IDLE: begin
                    next_state   = RMCFG_ADDR;
                    next_bit_cnt = 3'h0;
                end
                RMCFG_ADDR, RMCFG_DATA: begin
                    if (sck_rise) begin
                        next_rx_shift = shifted;
                        next_bit_cnt  = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7 && state == RMCFG_ADDR) begin
                            next_addr      = shifted[4:0];
                            next_read_op   = shifted[`RMCFG_READ_FLAG_BIT];
                            // Unmapped addresses read as zero.
                            next_sdo_shift = rmcfg_in_map(shifted[4:0]) ?
                                             bank[rmcfg_index(shifted[4:0])] : 8'h00;
                            next_state     = RMCFG_DATA;
                        end else if (bit_cnt == 3'h7) begin
                            // Reserved ramp bits land here too and stay inert. (R12)
                            if (!read_op && rmcfg_in_map(addr)) begin
                                next_bank[rmcfg_index(addr)] = shifted; // (R5) (R6)
                            end
                            next_state = RMCFG_ADDR;
                        end
                    end else if (sck_fall && state == RMCFG_DATA && bit_cnt != 3'h0) begin
                        // No shift before the first data bit keeps the MSB on the pin.
                        next_sdo_shift = {sdo_shift[6:0], 1'b0};
                    end
                end
                default: begin
                    next_state = RMCFG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bank      <= BANK_RESET; // (R7)
            state     <= RMCFG_IDLE;
            bit_cnt   <= 3'h0;
            rx_shift  <= 8'h00;
            sdo_shift <= 8'h00;
            addr      <= 5'h00;
            read_op   <= 1'b0;
        end else begin
            bank      <= next_bank;
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            rx_shift  <= next_rx_shift;
            sdo_shift <= next_sdo_shift;
            addr      <= next_addr;
            read_op   <= next_read_op;
        end
    end

    // ========
    // Buffer port: no address, the select's rising edge ends each byte.
    assign depth_bytes  = {5'h00, buf_reg[`RMCFG_DEPTH_HI:`RMCFG_DEPTH_LO]} * `RMCFG_DEPTH_STEP
                          + `RMCFG_DEPTH_STEP; // (R8)
    assign thresh_bytes = {1'b0, buf_reg[`RMCFG_THRESH_HI:`RMCFG_THRESH_LO]} + 7'h01; // (R9)
    assign o_fifo_empty     = (count == 7'h00);
    assign o_fifo_full      = (count >= depth_bytes);
    assign o_fifo_threshold = (count >= thresh_bytes); // (R9)

    always_comb begin
        next_fbit_cnt   = fbit_cnt;
        next_fin_shift  = fin_shift;
        next_fout_shift = fout_shift;
        host_push       = 1'b0;
        host_pop        = 1'b0;
        if (data_fall) begin
            next_fbit_cnt   = 4'h0;
            next_fout_shift = o_tx_byte;
        end else if (data_active && sck_rise) begin
            next_fin_shift = {fin_shift[6:0], i_sdi};
            next_fbit_cnt  = (fbit_cnt == 4'h8) ? 4'h8 : fbit_cnt + 4'h1;
        end else if (data_active && sck_fall && fbit_cnt != 4'h0) begin
            next_fout_shift = {fout_shift[6:0], 1'b0};
        end
        // A short or aborted byte leaves the pointers alone.
        if (data_rise && fbit_cnt == 4'h8) begin
            host_pop  = i_receive_mode & ~o_fifo_empty; // (R11)
            host_push = ~i_receive_mode & ~o_fifo_full; // (R11)
        end
    end

    // Host fills in transmit and drains in receive; the radio takes the other end.
    assign push      = i_receive_mode ? (i_rx_valid & ~o_fifo_full) : host_push;
    assign pop       = i_receive_mode ? host_pop : (i_tx_take & ~o_fifo_empty);
    assign push_data = i_receive_mode ? i_rx_byte : fin_shift;

    always_comb begin
        next_wr_ptr = push ? rmcfg_step(wr_ptr, depth_bytes) : wr_ptr;
        next_rd_ptr = pop ? rmcfg_step(rd_ptr, depth_bytes) : rd_ptr;
        next_count  = count + {6'h00, push} - {6'h00, pop};
        next_interrupt_line_zero     = ~i_receive_mode & o_fifo_threshold; // (R10)
        next_tx_start = next_interrupt_line_zero & ~interrupt_line_zero;                  // (R10)
        next_sdo      = i_config_select_n ? fout_shift[7] : sdo_shift[7];
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev_sck    <= 1'b0;
            prev_data_n <= 1'b1;
            fbit_cnt    <= 4'h0;
            fin_shift   <= 8'h00;
            fout_shift  <= 8'h00;
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= 7'h00;
            interrupt_line_zero        <= 1'b0;
            tx_start    <= 1'b0;
            sdo         <= 1'b0;
        end else begin
            prev_sck    <= i_sck;
            prev_data_n <= i_data_port_select_n;
            fbit_cnt    <= next_fbit_cnt;
            fin_shift   <= next_fin_shift;
            fout_shift  <= next_fout_shift;
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            interrupt_line_zero        <= next_interrupt_line_zero;
            tx_start    <= next_tx_start;
            sdo         <= next_sdo;
        end
    end

    rmcfg_fifo_mem #(
        .WIDTH  (8),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) u_mem (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (push),
        .i_wr_addr (wr_ptr),
        .i_wr_data (push_data),
        .i_rd_addr (rd_ptr),
        .o_rd_data (o_tx_byte)
    );

    // ========
    // Bit-rate enable; D below 15 is the host's fault and is used as written.
    always_comb begin
        logic [17:0] limit;
        limit = ({10'h000, i_bit_rate_c} + 18'h00001)
                * ({10'h000, bank[rmcfg_index(`RMCFG_OFF_BIT_RATE_D)]} + 18'h00001)
                * 18'h00002; // (R1)
        next_tick    = (div_cnt >= limit - 18'h00001);
        next_div_cnt = next_tick ? 18'h00000 : div_cnt + 18'h00001;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt <= 18'h00000;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    // ========
    // Outputs; the serial pin is released whenever no port is selected.
    assign o_sdo                 = sdo;
    assign o_sdo_oe_n            = i_config_select_n & i_data_port_select_n;
    assign o_bit_tick            = tick;
    assign o_interrupt_line_zero = interrupt_line_zero;
    assign o_tx_start            = tx_start;
    assign o_ramp_cycles         = rmcfg_ramp(ramp_reg[`RMCFG_RAMP_HI:`RMCFG_RAMP_LO]); // (R2)

    always_comb begin
        o_config.bit_rate_d          = bank[rmcfg_index(`RMCFG_OFF_BIT_RATE_D)];
        o_config.amplifier_ramp_time = ramp_reg[`RMCFG_RAMP_HI:`RMCFG_RAMP_LO]; // (R2)
        o_config.rx_low_power        = ramp_reg[`RMCFG_LOW_POWER_BIT];          // (R3)
        o_config.vco_trim            = ramp_reg[`RMCFG_TRIM_HI:`RMCFG_TRIM_LO];
        o_config.channel_set_select  = ramp_reg[`RMCFG_SET_SELECT_BIT];
        if (ramp_reg[`RMCFG_SET_SELECT_BIT]) begin // (R4)
            o_config.active_r_count = bank[rmcfg_index(`RMCFG_OFF_FREQ2_R)]; // (R6)
            o_config.active_p_count = bank[rmcfg_index(`RMCFG_OFF_FREQ2_P)];
            o_config.active_s_count = bank[rmcfg_index(`RMCFG_OFF_FREQ2_S)];
        end else begin
            o_config.active_r_count = bank[rmcfg_index(`RMCFG_OFF_FREQ1_R)]; // (R5)
            o_config.active_p_count = bank[rmcfg_index(`RMCFG_OFF_FREQ1_P)];
            o_config.active_s_count = bank[rmcfg_index(`RMCFG_OFF_FREQ1_S)];
        end
        o_config.fifo_depth_bytes = depth_bytes;
        o_config.fifo_threshold   = buf_reg[`RMCFG_THRESH_HI:`RMCFG_THRESH_LO];
    end

endmodule

`default_nettype wire

//--- rmcfg_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Port checker for the configuration bank.
module rmcfg_assertions
    import rmcfg_pkg::*;
(
    input wire logic             i_clock,               // Clock.
    input wire logic             i_sys_rst,             // Reset.
    input wire logic             i_config_select_n,     // Register select.
    input wire logic             i_data_port_select_n,  // Buffer select.
    input wire logic             i_receive_mode,        // Receive mode.
    input wire logic             o_sdo_oe_n,            // Serial enable.
    input wire logic             o_fifo_empty,          // Empty.
    input wire logic             o_fifo_full,           // Full.
    input wire logic             o_fifo_threshold,      // Threshold.
    input wire logic             o_interrupt_line_zero, // Line zero.
    input wire logic             o_tx_start,            // Start pulse.
    input wire logic             o_bit_tick,            // Bit tick.
    input wire logic [11:0]      o_ramp_cycles,         // Ramp cycles.
    input wire rmcfg_config_type o_config               // Settings.
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // The bank only moves inside a register frame, so idle selects freeze it.
    bank_hold_a: assert property (i_config_select_n && $past(i_config_select_n) &&
        $past(i_config_select_n, 2) |-> $stable(o_config))
        else $error("settings moved outside a frame");
    reset_set_a: assert property ($past(i_sys_rst) |-> o_config.active_r_count == 8'h6B &&
        o_config.active_p_count == 8'h2A && o_config.active_s_count == 8'h1E)
        else $error("first set not active after reset");
    ramp_map_a: assert property (o_ramp_cycles == (o_config.amplifier_ramp_time[1] ?
        (o_config.amplifier_ramp_time[0] ? 12'h8FC : 12'h5DC) :
        (o_config.amplifier_ramp_time[0] ? 12'h352 : 12'h12C))) else $error("ramp time wrong");
    line_zero_a: assert property (##1 o_interrupt_line_zero ==
        $past(!i_receive_mode && o_fifo_threshold)) else $error("line zero wrong");
    start_pulse_a: assert property ($rose(o_interrupt_line_zero) |-> o_tx_start ##1 !o_tx_start)
        else $error("start pulse wrong");
    empty_thresh_a: assert property (o_fifo_empty |-> !o_fifo_threshold && !o_fifo_full)
        else $error("empty buffer flags wrong");
    depth_set_a: assert property (
        o_config.fifo_depth_bytes inside {7'h10, 7'h20, 7'h30, 7'h40})
        else $error("depth not a legal size");
    tick_pulse_a: assert property (o_bit_tick |=> !o_bit_tick)
        else $error("tick longer than a cycle");
    pin_drive_a: assert property (o_sdo_oe_n == (i_config_select_n && i_data_port_select_n))
        else $error("serial enable wrong");
endmodule
bind rmcfg_top rmcfg_assertions i_rmcfg_assertions (.i_clock, .i_sys_rst, .i_config_select_n,
    .i_data_port_select_n, .i_receive_mode, .o_sdo_oe_n, .o_fifo_empty, .o_fifo_full,
    .o_fifo_threshold, .o_interrupt_line_zero, .o_tx_start, .o_bit_tick, .o_ramp_cycles,
    .o_config);
`default_nettype wire

//--- rmcfg_host.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Host controller on the serial port, mode 0, three cycles each clock phase.
module rmcfg_host (
    input  wire logic i_clock,  // Clock.
    input  wire logic i_sdo,    // Serial data in.
    output logic      o_sck,    // Serial clock.
    output logic      o_sdi,    // Serial data out.
    output logic      o_cfg_n,  // Register select.
    output logic      o_dat_n   // Buffer select.
);
    // Idle levels; the serial clock rests low between frames.
    initial begin
        o_sck = 1'b0;
        o_sdi = 1'b1;
        o_cfg_n = 1'b1;
        o_dat_n = 1'b1;
    end
    // Sample just before the rise, so a late shift still lands in time.
    task automatic bit_io(input logic b, output logic r);
        o_sdi <= b;
        repeat (3) @(posedge i_clock);
        r = i_sdo;
        o_sck <= 1'b1;
        repeat (3) @(posedge i_clock);
        o_sck <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int k = 7; k >= 0; k--) begin
            bit_io(d[k], q[k]);
        end
    endtask
    // Address byte then data byte; the caller keeps the divider within 15..255.
    task automatic reg_io(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] x;
        o_cfg_n <= 1'b0;
        @(posedge i_clock);
        byte_io(a, x);
        byte_io(d, q);
        repeat (3) @(posedge i_clock);
        o_cfg_n <= 1'b1;
        o_sdi <= ~d[0];
        repeat (3) @(posedge i_clock);
    endtask
    // One byte per select toggle, no address.
    task automatic fifo_io(input logic [7:0] d, output logic [7:0] q);
        o_dat_n <= 1'b0;
        @(posedge i_clock);
        byte_io(d, q);
        repeat (3) @(posedge i_clock);
        o_dat_n <= 1'b1;
        o_sdi <= ~d[0];
        repeat (3) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rmcfg_pkg::*;
    logic i_clock = 0, i_sys_rst = 1, i_receive_mode = 1, i_rx_valid = 0, i_tx_take = 0;
    logic [7:0] i_bit_rate_c = 8'h07, i_rx_byte = 8'h00, q;
    logic sck, sdi, cfg_n, dat_n, o_sdo, o_empty, o_full, o_thr, o_irq;
    logic [7:0] o_tx_byte;
    logic [11:0] o_ramp, ramp [4] = '{12'h12C, 12'h352, 12'h5DC, 12'h8FC};
    logic [7:0] rst_val [9] = '{8'h1F, 8'hC6, 8'h6B, 8'h2A, 8'h1E, 8'h77, 8'h2F, 8'h19, 8'h0F};
    logic tick;
    rmcfg_config_type cfg;
    int n_errors = 0, comparisons = 0, cycles = 0, n;
    // ========
    // Clock, design and host.
    always #5 i_clock = ~i_clock;
    rmcfg_top i_rmcfg_top (.i_clock, .i_sys_rst, .i_sck(sck), .i_sdi(sdi),
        .i_config_select_n(cfg_n), .i_data_port_select_n(dat_n), .o_sdo, .o_sdo_oe_n(),
        .i_receive_mode, .i_bit_rate_c, .i_rx_valid, .i_rx_byte, .i_tx_take, .o_tx_byte,
        .o_fifo_empty(o_empty), .o_fifo_full(o_full), .o_fifo_threshold(o_thr),
        .o_interrupt_line_zero(o_irq), .o_tx_start(), .o_bit_tick(tick),
        .o_ramp_cycles(o_ramp), .o_config(cfg));
    rmcfg_host i_rmcfg_host (.i_clock, .i_sdo(o_sdo), .o_sck(sck), .o_sdi(sdi),
        .o_cfg_n(cfg_n), .o_dat_n(dat_n));
    // ========
    // Helpers.
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_rmcfg_host.reg_io(a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        i_rmcfg_host.reg_io(8'h80 | a, 8'h00, q);
    endtask
    task automatic pulse(input bit take);
        if (take) i_tx_take <= 1'b1;
        else i_rx_valid <= 1'b1;
        @(posedge i_clock);
        {i_tx_take, i_rx_valid} <= 2'b00;
        repeat (2) @(posedge i_clock);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang counts as a failure; the whole run needs well under this.
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            conclude();
        end
    end
    // ========
    // Scenarios.
    task automatic test_reset;
        for (int i = 0; i < 9; i++) begin
            rd(8'h04 + i[7:0]);
            chk(q, rst_val[i]);
        end
        wr(8'h0D, 8'hFF);
        rd(8'h0D);
        chk(q, 8'h00);
        chk(cfg.fifo_depth_bytes, 7'h10);
        chk(cfg.fifo_threshold, 6'h0F);
        $display("test reset done");
    endtask
    task automatic test_ramp;
        for (int k = 0; k < 4; k++) begin
            wr(8'h05, {k[1:0], 6'h19});
            chk(o_ramp, ramp[k]);
            chk({cfg.rx_low_power, cfg.vco_trim, cfg.channel_set_select}, 4'h1);
            chk(cfg.active_r_count, 8'h77);
            chk({cfg.active_p_count, cfg.active_s_count}, 16'h2F19);
            rd(8'h05);
            chk(q, {k[1:0], 6'h19});
        end
        wr(8'h05, 8'h20);
        chk({cfg.rx_low_power, cfg.vco_trim, cfg.channel_set_select}, 4'h8);
        wr(8'h06, 8'hA5);
        wr(8'h07, 8'h5A);
        wr(8'h08, 8'h3C);
        chk({cfg.active_r_count, cfg.active_p_count}, 16'hA55A);
        chk(cfg.active_s_count, 8'h3C);
        $display("test ramp done");
    endtask
    // Smallest legal divider with C at zero: a bit every 2*1*16 cycles.
    task automatic test_tick;
        i_bit_rate_c <= 8'h00;
        wr(8'h04, 8'h0F);
        for (int j = 0; j < 2; j++) begin
            n = 0;
            @(posedge i_clock);
            while (tick !== 1'b1 && n < 300) begin
                @(posedge i_clock);
                n++;
            end
        end
        chk(n + 1, 12'd32);
        wr(8'h04, 8'h1F);
        $display("test tick done");
    endtask
    task automatic test_tx;
        i_receive_mode <= 1'b0;
        wr(8'h0C, 8'h03);
        for (int i = 0; i < 17; i++) begin
            i_rmcfg_host.fifo_io(8'h40 + i[7:0], q);
            if (i == 2) chk(o_thr, 1'b0);
            if (i == 3) chk({o_thr, o_irq}, 2'h3);
        end
        chk(o_full, 1'b1);
        for (int i = 0; i < 16; i++) begin
            chk(o_tx_byte, 8'h40 + i[7:0]);
            pulse(1'b1);
        end
        chk({o_empty, o_irq}, 2'h2);
        $display("test transmit done");
    endtask
    task automatic test_rx;
        i_receive_mode <= 1'b1;
        wr(8'h0C, 8'h40);
        chk(cfg.fifo_depth_bytes, 7'h20);
        i_rx_byte <= 8'hC3;
        pulse(1'b0);
        chk(o_thr, 1'b1);
        i_rx_byte <= 8'h3C;
        pulse(1'b0);
        i_rmcfg_host.fifo_io(8'h00, q);
        chk(q, 8'hC3);
        i_rmcfg_host.fifo_io(8'h00, q);
        chk({o_empty, q}, 12'h13C);
        $display("test receive done");
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clock);
        test_reset();
        test_ramp();
        test_tick();
        test_tx();
        test_rx();
        conclude();
    end
endmodule
`default_nettype wire
